// ---- verilog/oag_address_generator.sv ----
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Function
// - file address is 13 bits, lowest 8192 bytes, except moves use all 16
// - file ops use working register zero
// - three-operand op1 direct, op2 register/memory/literal5
// - plain indirect uses pointer unchanged
// - post-modify: address then pointer step
// - pre-modify: pointer step then address
// - indexed adds offset register, pointer kept
// - literal offset adds instruction literal
// - move ends share one offset field
// - mac reads use pointers eight to eleven
// - mac indexed only pointer nine, eleven
// - mac: indirect, indexed, post 2/4/6
// - branch 16-bit signed, disable 14-bit literal
// - one circular buffer in x, y
// - power-of-two buffers wrap both ways
// - length from start/end, max 32K words
// - y modulo addresses keep lsb clear
// - x select bits 3:0, enable bit 15
// - y select bits 7:4, enable bit 14
// - checks catch overshoot, not only equality
// - corrected value written back only pre/post
module oag_address_generator
  import oag_pkg::*;
#(
  parameter int NUM_PTR = 16                 // pointer register count
)(
  input  wire logic        ref_clk,          // core clock, 50 MHz
  input  wire logic        rst_n,            // sync reset, active low
  input  wire logic [7:0]  paddr,            // apb address
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb enable
  input  wire logic        pwrite,           // apb direction
  input  wire logic [31:0] pwdata,           // apb write data
  output logic      [31:0] prdata,           // apb read data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error
  input  wire oag_req_t    req,              // decode request
  input  wire logic [15:0] ptr_val,          // contents of req.ptr
  input  wire logic [15:0] base_val,         // contents of req.base
  output oag_resp_t        resp              // registered answer
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // pointer select is a 4-bit field, so any other count cannot be served
  if (NUM_PTR != 16)
  begin : g_num_ptr_check
    $error("pointer select is 4 bits, NUM_PTR must be 16");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] modulo_control;               // mode control
  logic [15:0] x_buffer_start;               // x circular start
  logic [15:0] x_buffer_end;                 // x circular end
  logic [15:0] y_buffer_start;               // y circular start
  logic [15:0] y_buffer_end;                 // y circular end
  logic [15:0] last_ea;                      // last address, for software

  logic [3:0]  x_modulo_pointer_select;      // decoded fields
  logic [3:0]  y_modulo_pointer_select;
  logic        x_modulo_enable;
  logic        y_modulo_enable;

  assign x_modulo_pointer_select = modulo_control[XWM_LSB +: 4];
  assign y_modulo_pointer_select = modulo_control[YWM_LSB +: 4];
  assign x_modulo_enable         = modulo_control[X_MODULO_ENABLE_BIT];
  assign y_modulo_enable         = modulo_control[Y_MODULO_ENABLE_BIT];

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // modulo correction for one space; overshoot tested, not equality
  function automatic logic [15:0] wrap(input logic [15:0] a,
                                       input logic [15:0] s,
                                       input logic [15:0] e,
                                       input logic        up,
                                       input logic        pow2);
    logic [15:0] len;
    len  = 16'(e - s + 16'h0001);
    wrap = a;
    // power-of-two buffers check both ends, others only travel way
    if ((up || pow2) && (a > e))
      wrap = 16'(a - len);
    else if ((!up || pow2) && (a < s))
      wrap = 16'(a + len);
  endfunction

  // length is a power of two when len & (len-1) is zero
  function automatic logic is_pow2(input logic [15:0] s,
                                   input logic [15:0] e);
    logic [15:0] len;
    len     = 16'(e - s + 16'h0001);
    is_pow2 = ((len & 16'(len - 16'h0001)) == 16'h0000);
  endfunction

  // ----------------------------------------------------------------
  // apb slave, one wait state
  // ----------------------------------------------------------------
  logic apb_acc;                             // access phase
  logic apb_hit;                             // mapped offset
  assign apb_acc = psel && penable;
  always_comb
  begin
    case (paddr)
      OFF_MODULO_CONTROL, OFF_X_BUFFER_START, OFF_X_BUFFER_END,
      OFF_Y_BUFFER_START, OFF_Y_BUFFER_END, OFF_LAST_ADDR:
        apb_hit = 1'b1;
      default:
        apb_hit = 1'b0;
    endcase
  end

  // register writes; last-address word is read only
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      modulo_control <= MODULO_CONTROL_RESET;        // modulo off at reset
      x_buffer_start <= BUF_RESET;
      x_buffer_end   <= BUF_RESET;
      y_buffer_start <= BUF_RESET;
      y_buffer_end   <= BUF_RESET;
    end
    // write lands only at the edge where ready is seen high
    else if (apb_acc && pwrite && pready)
    begin
      case (paddr)
        OFF_MODULO_CONTROL: modulo_control <= pwdata[15:0];
        OFF_X_BUFFER_START: x_buffer_start <= pwdata[15:0];
        OFF_X_BUFFER_END:   x_buffer_end   <= pwdata[15:0];
        // y space is word only, so start clears the lsb and end sets it
        OFF_Y_BUFFER_START: y_buffer_start <= {pwdata[15:1], 1'b0};
        OFF_Y_BUFFER_END:   y_buffer_end   <= {pwdata[15:1], 1'b1};
        default: ;
      endcase
    end
  end

  // read data and answer flags, registered
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // ready rises one cycle into access phase, then drops
      pready  <= apb_acc && !pready;
      pslverr <= apb_acc && !pready && !apb_hit;
      case (paddr)
        OFF_MODULO_CONTROL: prdata <= {16'h0000, modulo_control};
        OFF_X_BUFFER_START: prdata <= {16'h0000, x_buffer_start};
        OFF_X_BUFFER_END:   prdata <= {16'h0000, x_buffer_end};
        OFF_Y_BUFFER_START: prdata <= {16'h0000, y_buffer_start};
        OFF_Y_BUFFER_END:   prdata <= {16'h0000, y_buffer_end};
        OFF_LAST_ADDR:      prdata <= {16'h0000, last_ea};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // address generation, combinational
  // ----------------------------------------------------------------
  logic [15:0] raw_ea;                       // address before wrap
  logic [15:0] mod_ptr;                      // pointer after step
  logic        is_addr;                      // memory access
  logic        modifies;                     // pre/post mode
  logic        illegal;                      // disallowed combination
  logic        mod_on;                       // modulo applies here
  logic        up;                           // step direction
  logic [15:0] s_sel;                        // bounds of chosen space
  logic [15:0] e_sel;
  logic [15:0] wr_ea;                        // wrapped address
  logic [15:0] wr_ptr;                       // wrapped pointer
  logic [15:0] fin_ea;                       // final operand/address
  logic        y_sp;                         // effective space

  always_comb
  begin
    raw_ea   = ptr_val;
    mod_ptr  = ptr_val;
    is_addr  = 1'b1;
    modifies = 1'b0;
    illegal  = 1'b0;
    y_sp     = req.space_y;
    case (req.mode)
      OAG_FILE:
      begin
        // file field is 13 bits unless a move reaches all space
        raw_ea = (req.iclass == OAG_CLS_MOVE) ? req.literal
               : (req.literal & NEAR_MASK);
      end
      OAG_DIRECT:
      begin
        raw_ea  = ptr_val;                               // operand one
        is_addr = 1'b0;
      end
      OAG_INDIRECT:
        raw_ea = ptr_val;
      OAG_POST:
      begin
        raw_ea   = ptr_val;
        mod_ptr  = 16'(ptr_val + req.step);
        modifies = 1'b1;
      end
      OAG_PRE:
      begin
        mod_ptr  = 16'(ptr_val + req.step);
        raw_ea   = mod_ptr;
        modifies = 1'b1;
      end
      OAG_INDEXED:
        raw_ea = 16'(ptr_val + base_val);
      OAG_LIT_OFS:
        raw_ea = 16'(ptr_val + req.literal);
      OAG_LITERAL:
      begin
        is_addr = 1'b0;
        case (req.iclass)
          // branch target is 16-bit signed, disable count 14-bit
          OAG_CLS_OTHER: raw_ea = req.literal;
          OAG_CLS_MCU:   raw_ea = {11'h000, req.literal[4:0]};
          default:       raw_ea = req.literal;
        endcase
        if (req.iclass == OAG_CLS_OTHER && req.space_y)
          raw_ea = {2'b00, req.literal[13:0]};
      end
      default:
        illegal = 1'b1;
    endcase
    // mac prefetch: pointers 8..11 only, space fixed by pointer
    if (req.iclass == OAG_CLS_MAC)
    begin
      if (req.ptr < PTR_MAC_X0 || req.ptr > PTR_MAC_Y1)
        illegal = 1'b1;
      y_sp = (req.ptr >= PTR_MAC_Y0);
      if (req.mode == OAG_INDEXED && req.ptr != PTR_MAC_X1 && req.ptr != PTR_MAC_Y1)
        illegal = 1'b1;
      if (!(req.mode == OAG_INDIRECT || req.mode == OAG_INDEXED || req.mode == OAG_POST))
        illegal = 1'b1;
      if (req.mode == OAG_POST && !(req.step == 16'sd2 || req.step == 16'sd4
          || req.step == 16'sd6 || req.step == -16'sd2 || req.step == -16'sd4
          || req.step == -16'sd6))
        illegal = 1'b1;
    end
  end

  // one buffer per space; select 15 or clear enable turns it off
  always_comb
  begin
    s_sel  = y_sp ? y_buffer_start : x_buffer_start;
    e_sel  = y_sp ? y_buffer_end   : x_buffer_end;
    mod_on = is_addr && req.mode != OAG_FILE &&
             (y_sp ? (y_modulo_enable && y_modulo_pointer_select != PTR_NONE
                      && y_modulo_pointer_select == req.ptr)
                   : (x_modulo_enable && x_modulo_pointer_select != PTR_NONE
                      && x_modulo_pointer_select == req.ptr));
    up     = !req.step[15];
    wr_ea  = wrap(raw_ea, s_sel, e_sel, up, is_pow2(s_sel, e_sel));
    wr_ptr = wrap(mod_ptr, s_sel, e_sel, up, is_pow2(s_sel, e_sel));
    fin_ea = mod_on ? wr_ea : raw_ea;
    if (mod_on && y_sp)
      fin_ea = {fin_ea[15:1], 1'b0};
  end

  // ----------------------------------------------------------------
  // registered answer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      resp    <= '0;
      last_ea <= 16'h0000;
    end
    else
    begin
      resp.valid    <= req.valid;
      resp.is_addr  <= is_addr;
      resp.ea       <= fin_ea;
      resp.illegal  <= illegal;
      // file ops send result to working register zero or file
      resp.dest_reg <= (req.mode == OAG_FILE) ? req.dest_default_working_register
                     : !is_addr;
      // only pre/post modes write the pointer back
      resp.wb_en    <= req.valid && modifies && !illegal;
      resp.wb_ptr   <= (req.mode == OAG_FILE) ? PTR_W0 : req.ptr;
      resp.wb_val   <= mod_on ? wr_ptr : mod_ptr;
      if (req.valid)
        last_ea <= fin_ea;
    end
  end

endmodule

// ---- verilog/oag_pkg.sv ----
package oag_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on apb)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_MODULO_CONTROL = 8'h00;  // modulo control
  localparam logic [7:0]  OFF_X_BUFFER_START = 8'h04;  // x buffer start
  localparam logic [7:0]  OFF_X_BUFFER_END   = 8'h08;  // x buffer end
  localparam logic [7:0]  OFF_Y_BUFFER_START = 8'h0C;  // y buffer start
  localparam logic [7:0]  OFF_Y_BUFFER_END   = 8'h10;  // y buffer end
  localparam logic [7:0]  OFF_LAST_ADDR      = 8'h14;  // last x/y address, read only

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          XWM_LSB            = 0;      // x pointer select 3:0
  localparam int          YWM_LSB            = 4;      // y pointer select 7:4
  localparam int          Y_MODULO_ENABLE_BIT         = 14;     // y modulo enable
  localparam int          X_MODULO_ENABLE_BIT         = 15;     // x modulo enable
  localparam logic [15:0] MODULO_CONTROL_RESET       = 16'h00FF; // both selects = 15
  localparam logic [15:0] BUF_RESET          = 16'h0000; // buffer bounds
  localparam logic [3:0]  PTR_NONE           = 4'hF;   // select value disabling modulo
  localparam logic [3:0]  PTR_W0             = 4'h0;   // implied working register
  localparam logic [3:0]  PTR_MAC_X0         = 4'h8;   // mac x pointers 8,9
  localparam logic [3:0]  PTR_MAC_X1         = 4'h9;
  localparam logic [3:0]  PTR_MAC_Y0         = 4'hA;   // mac y pointers 10,11
  localparam logic [3:0]  PTR_MAC_Y1         = 4'hB;
  localparam logic [15:0] NEAR_MASK          = 16'h1FFF; // 13-bit file field, 8192 bytes
  localparam logic [15:0] MAX_LEN_BYTES      = 16'hFFFF; // 32K words max span

  // ----------------------------------------------------------------
  // addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OAG_FILE,        // file register direct
    OAG_DIRECT,      // register direct
    OAG_INDIRECT,    // [ptr]
    OAG_POST,        // [ptr], ptr += step
    OAG_PRE,         // ptr += step, [ptr]
    OAG_INDEXED,     // [ptr + base]
    OAG_LIT_OFS,     // [ptr + literal]
    OAG_LITERAL      // literal operand, no address
  } oag_mode_t;

  typedef enum logic [1:0] {
    OAG_CLS_MCU,     // general / three-operand
    OAG_CLS_MOVE,    // move / accumulator, full data space
    OAG_CLS_MAC,     // dual-operand mac prefetch
    OAG_CLS_OTHER    // branch / interrupt-disable literals
  } oag_class_t;

  // one request from decode
  typedef struct packed {
    logic            valid;      // request strobe
    oag_class_t      iclass;     // instruction class
    oag_mode_t       mode;       // addressing mode
    logic [3:0]      ptr;        // pointer register select
    logic [3:0]      base;       // shared 4-bit offset register field
    logic            space_y;    // 1: y generator
    logic            dest_default_working_register;  // file op result to working register
    logic signed [15:0] step;    // signed modify constant in bytes
    logic [15:0]     literal;    // literal / file field / offset
  } oag_req_t;

  // one answer to execute
  typedef struct packed {
    logic            valid;      // answer strobe
    logic            is_addr;    // ea holds a memory address
    logic [15:0]     ea;         // effective address or operand
    logic            wb_en;      // pointer write-back
    logic [3:0]      wb_ptr;     // which pointer
    logic [15:0]     wb_val;     // value written back
    logic            dest_reg;   // result goes to a register
    logic            illegal;    // mode or pointer not allowed
  } oag_resp_t;

endpackage

// ---- tb/oag_decode_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// pointer file of the decode pipeline
// ----------------------------------------
module oag_decode_model
  import oag_pkg::*;
(
  input  wire logic      ref_clk,   // core clock
  input  wire oag_req_t  req,       // request being issued
  input  wire oag_resp_t resp,      // answer from the generator
  output logic [15:0]    ptr_val,   // selected pointer contents
  output logic [15:0]    base_val   // selected offset register
);
  logic [15:0] regs [16];  // working registers, preloaded by the bench

  // reads are combinational: the generator samples them with the request
  assign ptr_val  = regs[req.ptr];
  assign base_val = regs[req.base];

  // write-back lands at the answer edge, so a chained request sees it
  always @(posedge ref_clk)
    if (resp.valid && resp.wb_en)
      regs[resp.wb_ptr] <= resp.wb_val;
endmodule

// ---- tb/oag_address_generator_properties.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the address generator
// ----------------------------------------
module oag_checker
  import oag_pkg::*;
(
  input wire logic        ref_clk,   // core clock
  input wire logic        rst_n,     // sync reset, active low
  input wire logic [7:0]  paddr,     // apb address
  input wire logic        psel,      // apb select
  input wire logic        penable,   // apb enable
  input wire logic        pwrite,    // apb direction
  input wire logic [31:0] pwdata,    // apb write data
  input wire logic        pready,    // apb ready
  input wire oag_req_t    req,       // decode request
  input wire logic [15:0] ptr_val,   // pointer contents
  input wire logic [15:0] base_val,  // offset register contents
  input wire oag_resp_t   resp       // registered answer
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] mc;   // shadow of modulo control
  logic        hit;  // request pointer is under modulo
  logic        go;   // non-mac request with plain arithmetic
  logic        mac;  // mac request

  // shadow follows apb writes so modulo pointers can be left out below
  always_ff @(posedge ref_clk)
    if (!rst_n)
      mc <= MODULO_CONTROL_RESET;
    else if (psel && penable && pwrite && pready && paddr == OFF_MODULO_CONTROL)
      mc <= pwdata[15:0];
  assign hit = (mc[15] && mc[3:0] != PTR_NONE && req.ptr == mc[3:0]) ||
               (mc[14] && mc[7:4] != PTR_NONE && req.ptr == mc[7:4]);
  assign go  = req.valid && !hit && req.iclass != OAG_CLS_MAC;
  assign mac = req.valid && req.iclass == OAG_CLS_MAC;

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_file; go && req.iclass == OAG_CLS_MCU && req.mode == OAG_FILE |=>
    resp.ea == ($past(req.literal) & NEAR_MASK) && resp.dest_reg == $past(req.dest_default_working_register);
  endproperty
  a_file: assert property (p_file) else $error("file address wrong");
  property p_ind; go && req.mode == OAG_INDIRECT |=> resp.ea == $past(ptr_val) && !resp.wb_en;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect address wrong");
  property p_post; go && req.mode == OAG_POST |=> resp.ea == $past(ptr_val) && resp.wb_en
    && resp.wb_val == $past(ptr_val + req.step) && resp.wb_ptr == $past(req.ptr);
  endproperty
  a_post: assert property (p_post) else $error("post modify wrong");
  property p_pre; go && req.mode == OAG_PRE |=> resp.ea == $past(ptr_val + req.step)
    && resp.wb_en && resp.wb_val == resp.ea;
  endproperty
  a_pre: assert property (p_pre) else $error("pre modify wrong");
  property p_idx; go && req.mode == OAG_INDEXED |=>
    resp.ea == $past(ptr_val + base_val) && !resp.wb_en;
  endproperty
  a_idx: assert property (p_idx) else $error("indexed address wrong");
  property p_lof; go && req.mode == OAG_LIT_OFS |=>
    resp.ea == $past(ptr_val + req.literal) && !resp.wb_en;
  endproperty
  a_lof: assert property (p_lof) else $error("literal offset wrong");
  property p_macp; mac && (req.ptr < PTR_MAC_X0 || req.ptr > PTR_MAC_Y1) |=>
    resp.illegal && !resp.wb_en;
  endproperty
  a_macp: assert property (p_macp) else $error("mac pointer accepted");
  property p_macx; mac && req.mode == OAG_INDEXED && req.ptr != PTR_MAC_X1 &&
    req.ptr != PTR_MAC_Y1 |=> resp.illegal;
  endproperty
  a_macx: assert property (p_macx) else $error("mac indexed pointer accepted");
  property p_macs; mac && req.mode == OAG_POST && req.ptr >= PTR_MAC_X0 && req.ptr <= PTR_MAC_Y1
    |=> resp.illegal == !($past(req.step) inside {2, 4, 6, -2, -4, -6});
  endproperty
  a_macs: assert property (p_macs) else $error("mac step handling wrong");
  property p_apb; psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb ready timing wrong");
endmodule

bind oag_address_generator oag_checker oag_checker_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .req(req), .ptr_val(ptr_val),
  .base_val(base_val), .resp(resp)
);

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import oag_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam oag_class_t C_MCU = OAG_CLS_MCU;    // short aliases keep op lines narrow
  localparam oag_class_t C_MOV = OAG_CLS_MOVE;
  localparam oag_class_t C_MAC = OAG_CLS_MAC;
  localparam oag_class_t C_OTH = OAG_CLS_OTHER;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;  // clock, apb
  logic [7:0]  paddr;        // apb address
  logic [31:0] pwdata;       // apb write data
  logic [31:0] prdata;       // apb read data
  oag_req_t    req;          // decode request
  logic [15:0] ptr_val;      // pointer contents
  logic [15:0] base_val;     // offset register contents
  oag_resp_t   resp;         // generator answer
  int          miscompares;  // mismatches seen
  int          compares;     // comparisons made
  logic [31:0] rd;           // last read data
  logic        er;           // last error flag
  logic [15:0] a;            // running pointer expectation

  oag_address_generator oag_address_generator_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req(req), .ptr_val(ptr_val), .base_val(base_val), .resp(resp));
  oag_decode_model oag_decode_model_inst (
    .ref_clk(ref_clk), .req(req), .resp(resp), .ptr_val(ptr_val), .base_val(base_val));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits for ready, a stuck slave counts as a mismatch
  task automatic apb(input logic w, input logic [7:0] ad, input logic [15:0] d);
    int n;
    @(posedge ref_clk);
    psel   <= 1'b1;
    paddr  <= ad;
    pwrite <= w;
    pwdata <= {16'h0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      chk(32'h0, 32'h1);
  endtask

  task automatic apb_rd(input logic [7:0] ad, input logic [31:0] exp, input logic ee);
    apb(1'b0, ad, 16'h0000);
    chk(rd, exp);
    chk(er, ee);
  endtask

  // one request, answer checked at the edge where it stands
  task automatic op(input oag_class_t c, input oag_mode_t m, input logic [3:0] p,
                    input logic y, input logic [15:0] s, input logic [15:0] l,
                    input logic [15:0] ea, input logic wb, input logic [15:0] wv,
                    input logic il);
    logic adr;
    adr = !(m inside {OAG_DIRECT, OAG_LITERAL});
    @(posedge ref_clk);
    req.valid     <= 1'b1;
    req.iclass    <= c;
    req.mode      <= m;
    req.ptr       <= p;
    req.base      <= 4'h2;
    req.space_y   <= y && m != OAG_FILE;
    req.dest_default_working_register <= y;
    req.step      <= s;
    req.literal   <= l;
    @(posedge ref_clk);
    req.valid <= 1'b0;
    @(posedge ref_clk);
    chk(resp.valid, 1'b1);
    chk(resp.illegal, il);
    if (!il)
      chk(resp.is_addr, adr);
    if (!il && m != OAG_DIRECT)
      chk(resp.ea, ea);
    if (m == OAG_FILE)
      chk(resp.dest_reg, y);
    if (il || (adr && m != OAG_FILE))
      chk(resp.wb_en, wb);
    if (wb)
      chk({resp.wb_ptr, resp.wb_val}, {p, wv});
  endtask

  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // watchdog: the whole run needs well under 1000 cycles
  // ----------------------------------------
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    miscompares++;
    report_and_stop();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    miscompares = 0;
    compares = 0;
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    req = '0;
    for (int i = 0; i < 16; i++)
      oag_decode_model_inst.regs[i] = 16'h0100 * i[15:0];
    oag_decode_model_inst.regs[5]  = 16'h100E;  // x buffer pointer
    oag_decode_model_inst.regs[7]  = 16'h100E;  // same address, not selected
    oag_decode_model_inst.regs[15] = 16'h100E;  // stack pointer slot
    oag_decode_model_inst.regs[6]  = 16'h2006;  // y buffer pointer
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb_rd(OFF_MODULO_CONTROL, 32'h000000FF, 1'b0);
    apb_rd(OFF_X_BUFFER_END, 32'h0, 1'b0);
    apb_rd(8'h18, 32'h0, 1'b1);
    apb(1'b1, OFF_Y_BUFFER_START, 16'h2001);
    apb(1'b1, OFF_Y_BUFFER_END, 16'h2006);
    apb_rd(OFF_Y_BUFFER_START, 32'h2000, 1'b0);
    apb_rd(OFF_Y_BUFFER_END, 32'h2007, 1'b0);
    $display("registers done");
    op(C_MCU, OAG_FILE, 4'h3, 1'b1, 16'h0, 16'hFFFF, 16'h1FFF, 1'b0, 16'h0, 1'b0);
    op(C_MCU, OAG_FILE, 4'h3, 1'b0, 16'h0, 16'h2345, 16'h0345, 1'b0, 16'h0, 1'b0);
    op(C_MCU, OAG_DIRECT, 4'h3, 1'b0, 16'h0, 16'h0, 16'h0, 1'b0, 16'h0, 1'b0);
    op(C_MCU, OAG_LITERAL, 4'h3, 1'b0, 16'h0, 16'hFFEA, 16'h000A, 1'b0, 16'h0, 1'b0);
    op(C_MCU, OAG_INDIRECT, 4'h3, 1'b0, 16'h0, 16'h0, 16'h0300, 1'b0, 16'h0, 1'b0);
    op(C_MCU, OAG_POST, 4'h3, 1'b0, 16'h2, 16'h0, 16'h0300, 1'b1, 16'h0302, 1'b0);
    op(C_MCU, OAG_PRE, 4'h3, 1'b0, 16'hFFFC, 16'h0, 16'h02FE, 1'b1, 16'h02FE, 1'b0);
    op(C_MOV, OAG_INDEXED, 4'h3, 1'b0, 16'h0, 16'h0, 16'h04FE, 1'b0, 16'h0, 1'b0);
    op(C_MOV, OAG_LIT_OFS, 4'h3, 1'b0, 16'h0, 16'h0010, 16'h030E, 1'b0, 16'h0, 1'b0);
    op(C_OTH, OAG_LITERAL, 4'h3, 1'b0, 16'h0, 16'h8001, 16'h8001, 1'b0, 16'h0, 1'b0);
    op(C_OTH, OAG_LITERAL, 4'h3, 1'b1, 16'h0, 16'hFFFF, 16'h3FFF, 1'b0, 16'h0, 1'b0);
    $display("plain modes done");
    op(C_MAC, OAG_INDIRECT, 4'h8, 1'b0, 16'h0, 16'h0, 16'h0800, 1'b0, 16'h0, 1'b0);
    op(C_MAC, OAG_INDIRECT, 4'h3, 1'b0, 16'h0, 16'h0, 16'h0, 1'b0, 16'h0, 1'b1);
    op(C_MAC, OAG_INDEXED, 4'h8, 1'b0, 16'h0, 16'h0, 16'h0, 1'b0, 16'h0, 1'b1);
    op(C_MAC, OAG_INDEXED, 4'hB, 1'b0, 16'h0, 16'h0, 16'h0D00, 1'b0, 16'h0, 1'b0);
    a = 16'h0A00;
    for (int k = 2; k <= 6; k += 2)
    begin
      op(C_MAC, OAG_POST, 4'hA, 1'b0, 16'(k), 16'h0, a, 1'b1, a + 16'(k), 1'b0);
      a = a + 16'(k);
    end
    op(C_MAC, OAG_POST, 4'hA, 1'b0, 16'h8, 16'h0, 16'h0, 1'b0, 16'h0, 1'b1);
    $display("mac modes done");
    apb(1'b1, OFF_X_BUFFER_START, 16'h1000);
    apb(1'b1, OFF_X_BUFFER_END, 16'h100F);
    apb(1'b1, OFF_MODULO_CONTROL, 16'h80F5);  // x on pointer five
    op(C_MCU, OAG_POST, 4'h5, 1'b0, 16'h4, 16'h0, 16'h100E, 1'b1, 16'h1002, 1'b0);
    op(C_MCU, OAG_PRE, 4'h5, 1'b0, 16'hFFFC, 16'h0, 16'h100E, 1'b1, 16'h100E, 1'b0);
    op(C_MOV, OAG_LIT_OFS, 4'h5, 1'b0, 16'h0, 16'h4, 16'h1002, 1'b0, 16'h0, 1'b0);
    op(C_MCU, OAG_POST, 4'h7, 1'b0, 16'h4, 16'h0, 16'h100E, 1'b1, 16'h1012, 1'b0);
    apb(1'b1, OFF_MODULO_CONTROL, 16'h00F5);
    op(C_MCU, OAG_POST, 4'h5, 1'b0, 16'h4, 16'h0, 16'h100E, 1'b1, 16'h1012, 1'b0);
    apb(1'b1, OFF_MODULO_CONTROL, 16'h80FF);
    op(C_MCU, OAG_POST, 4'hF, 1'b0, 16'h4, 16'h0, 16'h100E, 1'b1, 16'h1012, 1'b0);
    apb(1'b1, OFF_MODULO_CONTROL, 16'h406F);  // y on pointer six
    op(C_MCU, OAG_POST, 4'h6, 1'b1, 16'h2, 16'h0, 16'h2006, 1'b1, 16'h2000, 1'b0);
    op(C_MCU, OAG_PRE, 4'h6, 1'b1, 16'hFFFE, 16'h0, 16'h2006, 1'b1, 16'h2006, 1'b0);
    apb_rd(OFF_LAST_ADDR, 32'h2006, 1'b0);
    $display("modulo done");
    report_and_stop();
  end
endmodule
